// ---- shared/adc_seq_consts.vh ----
// named constants for the converter sequencer and its result read port
// assumes inclusion by bare name from the design files under logic/
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// ----------------------------------------------------------------
// timing in states of the system clock, full-rate peripheral clock
// ----------------------------------------------------------------
`define SYNC_DELAY_SLOW   9'h00A   // synchronisation delay, slow clock selection
`define SYNC_DELAY_FAST   9'h006   // synchronisation delay, fast clock selection
`define SAMPLE_SLOW       9'h050   // sampling time, 80 states
`define SAMPLE_FAST       9'h028   // sampling time, 40 states
`define STEP_SLOW         9'h010   // one approximation step, slow clock selection
`define STEP_FAST         9'h008   // one approximation step, fast clock selection
`define SAR_STEPS         4'hB     // ten bit trials plus one settle step
`define SAR_TOP_BIT       4'h9     // first bit tried
`define ZERO_DELAY        9'h000   // no synchronisation delay in a running scan
`define HANDOFF_TRIM      9'h003   // settle step shortened by the two relaunch edges

// ----------------------------------------------------------------
// result layout and reset values
// ----------------------------------------------------------------
`define RESULT_RESET      16'h0000 // result registers after reset or standby
`define RESULT_PAD        6'h00    // unused low bits of a left-justified result
`define BYTE_RESET        8'h00    // read data and holding latch after reset
`define CHAN_FIRST        2'h0     // first input of a group

`endif

// ---- logic/sar_engine.v ----
// successive-approximation timing engine: delay, sample, ten trials, settle
// assumes comp_in is the comparator output on the same clock as clk
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module sar_engine (
    input  wire       clk,        // system clock
    input  wire       reset_n,    // asynchronous reset, active low
    input  wire       go,         // pulse: begin a conversion
    input  wire       abort,      // level: drop any conversion in progress
    input  wire [8:0] delay_len,  // synchronisation delay in states, zero to skip
    input  wire [8:0] sample_len, // sampling time in states
    input  wire [8:0] step_len,   // states per approximation step
    input  wire       comp_in,    // comparator: input at or above trial code
    output reg        busy,       // conversion in progress
    output reg        sampling,   // sample-and-hold closed
    output reg  [9:0] trial_code, // code presented to the comparator
    output reg        done,       // pulse: result valid
    output reg  [9:0] result      // last finished result
);

    localparam [1:0] ST_IDLE   = 2'b00;
    localparam [1:0] ST_DELAY  = 2'b01;
    localparam [1:0] ST_SAMPLE = 2'b10;
    localparam [1:0] ST_CONV   = 2'b11;

    reg [1:0] state;
    reg [8:0] count;
    reg [3:0] step;

    // ----------------------------------------------------------------
    // sequence through delay, sample and trials
    // ----------------------------------------------------------------
    // each trial step ends by keeping or dropping the bit under trial; the settle step hands out the result
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state      <= ST_IDLE;
            count      <= 9'h000;
            step       <= 4'h0;
            busy       <= 1'b0;
            sampling   <= 1'b0;
            trial_code <= 10'h000;
            done       <= 1'b0;
            result     <= 10'h000;
        end else begin
            done <= 1'b0;
            if (abort) begin
                state    <= ST_IDLE;
                busy     <= 1'b0;
                sampling <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (go) begin
                            busy <= 1'b1;
                            if (delay_len == `ZERO_DELAY) begin
                                state    <= ST_SAMPLE;
                                sampling <= 1'b1;
                                count    <= sample_len - 9'h001;
                            end else begin
                                state <= ST_DELAY;
                                count <= delay_len - 9'h001;
                            end
                        end
                    end
                    ST_DELAY: begin
                        if (count == 9'h000) begin
                            state    <= ST_SAMPLE;
                            sampling <= 1'b1;
                            count    <= sample_len - 9'h001;
                        end else begin
                            count <= count - 9'h001;
                        end
                    end
                    ST_SAMPLE: begin
                        if (count == 9'h000) begin
                            state      <= ST_CONV;
                            sampling   <= 1'b0;
                            step       <= `SAR_TOP_BIT;
                            trial_code <= 10'h200;
                            count      <= step_len - 9'h001;
                        end else begin
                            count <= count - 9'h001;
                        end
                    end
                    ST_CONV: begin
                        if (count != 9'h000) begin
                            count <= count - 9'h001;
                        end else if (step == 4'hF) begin
                            // settle step over: hand the result out
                            state  <= ST_IDLE;
                            busy   <= 1'b0;
                            done   <= 1'b1;
                            result <= trial_code;
                        end else begin
                            // settle step gives back the two edges the sequencer needs
                            // to relaunch, so back-to-back scan conversions stay 256/128
                            if (step == 4'h0)
                                count <= step_len - `HANDOFF_TRIM;
                            else
                                count <= step_len - 9'h001;
                            step  <= step - 4'h1;
                            if (!comp_in)
                                trial_code[step] <= 1'b0;
                            if (step != 4'h0)
                                trial_code[step - 4'h1] <= 1'b1;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

endmodule // sar_engine

// ---- logic/adc_sequencer.v ----
// control for an eight-input 10-bit converter: modes, start, flag, byte reads
// assumes control bits arrive as same-clock levels and pulses from the cpu side;
// only the trigger pin comes from outside the clock domain
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module adc_sequencer (
    input  wire       clk,                 // system clock, 40 MHz
    input  wire       reset_n,             // asynchronous reset, active low
    input  wire       standby,             // level: standby mode, clears state
    input  wire       half_rate_pclk,      // level: peripheral clock at half rate
    input  wire       start_set,           // pulse: software writes start bit 1
    input  wire       start_clear,         // pulse: software writes start bit 0
    input  wire       scan_mode,           // level: 1 scan, 0 single
    input  wire       fast_clock_select,   // level: shorter conversion time
    input  wire       group_select_bit,    // level: inputs 4-7 when 1
    input  wire       channel_select_bit1, // level: channel select bit 1
    input  wire       channel_select_bit0, // level: channel select bit 0
    input  wire       conv_irq_enable,     // level: interrupt enable
    input  wire       ext_trigger_enable,  // level: trigger pin may start
    input  wire       ext_trigger_n,       // pin: trigger, active low, asynchronous
    input  wire       status_read,         // pulse: status register read
    input  wire       flag_write_zero,     // pulse: zero written to the end flag
    input  wire       rd_upper,            // pulse: read upper result byte
    input  wire       rd_lower,            // pulse: read lower result byte
    input  wire [1:0] rd_sel,              // result register for an upper read
    input  wire       comp_in,             // comparator output, same clock
    output reg  [7:0] rd_data,             // read data, held until next read
    output reg        conv_start_bit,      // start bit as read back
    output reg        conv_end_flag,       // end flag as read back
    output reg        conv_end_irq,        // interrupt request, level
    output reg  [2:0] analog_select,       // input routed to sample-and-hold
    output reg        sample_hold,         // sample-and-hold closed
    output reg  [9:0] dac_code             // trial code for the comparator
);

    reg  [15:0] result_reg_a;  // input 0 or 4
    reg  [15:0] result_reg_b;  // input 1 or 5
    reg  [15:0] result_reg_c;  // input 2 or 6
    reg  [15:0] result_reg_d;  // input 3 or 7
    reg  [7:0]  hold_latch;
    reg  [1:0]  cur_chan;
    reg         scan_run;
    reg         flag_armed;
    reg  [2:0]  trig_sync;
    reg         eng_go;
    reg  [8:0]  eng_delay;
    wire        eng_busy;
    wire        eng_sampling;
    wire [9:0]  eng_code;
    wire        eng_done;
    wire [9:0]  eng_result;
    wire [1:0]  chan_bits;
    wire        trig_fall;
    wire        start_req;
    wire        flag_set;
    wire        last_chan;
    wire [8:0]  sample_len;
    wire [8:0]  step_len;
    wire [8:0]  delay_len;
    wire [15:0] rd_word;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // doubles a state count when the peripheral clock runs at half rate
    function [8:0] scale;
        input [8:0] states;
        input       half;
        begin
            scale = half ? {states[7:0], 1'b0} : states;
        end
    endfunction

    // whole word of a selected result register
    function [15:0] pick;
        input [1:0]  sel;
        input [15:0] a;
        input [15:0] b;
        input [15:0] c;
        input [15:0] d;
        begin
            case (sel)
                2'h0:    pick = a;
                2'h1:    pick = b;
                2'h2:    pick = c;
                default: pick = d;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // timing selection
    // ----------------------------------------------------------------
    // fixed delay plus 256/128 states gives 266/134 states in all
    assign delay_len  = scale(fast_clock_select ? `SYNC_DELAY_FAST : `SYNC_DELAY_SLOW,
                              half_rate_pclk);
    assign sample_len = scale(fast_clock_select ? `SAMPLE_FAST : `SAMPLE_SLOW,
                              half_rate_pclk);
    assign step_len   = scale(fast_clock_select ? `STEP_FAST : `STEP_SLOW,
                              half_rate_pclk);

    // ----------------------------------------------------------------
    // start sources
    // ----------------------------------------------------------------
    // trigger pin passes two flops; the third holds the old level for the edge
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            trig_sync <= 3'b111;
        else
            trig_sync <= {trig_sync[1:0], ext_trigger_n};
    end

    assign trig_fall = ext_trigger_enable & trig_sync[2] & ~trig_sync[1];
    assign start_req = (start_set | trig_fall) & ~conv_start_bit;
    assign chan_bits = {channel_select_bit1, channel_select_bit0};
    assign last_chan = (cur_chan == chan_bits);
    assign flag_set  = eng_done & (~scan_mode | last_chan);

    // ----------------------------------------------------------------
    // start bit, scan position and engine launch
    // ----------------------------------------------------------------
    // a new start always reads the selection bits as they stand now
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_start_bit <= 1'b0;
            scan_run       <= 1'b0;
            cur_chan       <= `CHAN_FIRST;
            eng_go         <= 1'b0;
            eng_delay      <= `ZERO_DELAY;
        end else if (standby) begin
            conv_start_bit <= 1'b0;
            scan_run       <= 1'b0;
            cur_chan       <= `CHAN_FIRST;
            eng_go         <= 1'b0;
            eng_delay      <= `ZERO_DELAY;
        end else begin
            eng_go <= 1'b0;
            if (start_clear) begin
                conv_start_bit <= 1'b0;
                scan_run       <= 1'b0;
            end else if (start_req) begin
                conv_start_bit <= 1'b1;
                scan_run       <= scan_mode;
                eng_go         <= 1'b1;
                eng_delay      <= delay_len;
                // scan begins at the group's first input; single takes the pick
                cur_chan <= scan_mode ? `CHAN_FIRST : chan_bits;
            end else if (eng_done) begin
                if (!scan_run) begin
                    conv_start_bit <= 1'b0;
                end else begin
                    // next input follows at once, no synchronisation delay
                    eng_go    <= 1'b1;
                    eng_delay <= `ZERO_DELAY;
                    cur_chan  <= last_chan ? `CHAN_FIRST : cur_chan + 2'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // conversion engine
    // ----------------------------------------------------------------
    // clearing the start bit or standby aborts the running conversion
    sar_engine u_sar (
        .clk        (clk),
        .reset_n    (reset_n),
        .go         (eng_go),
        .abort      (start_clear | standby),
        .delay_len  (eng_delay),
        .sample_len (sample_len),
        .step_len   (step_len),
        .comp_in    (comp_in),
        .busy       (eng_busy),
        .sampling   (eng_sampling),
        .trial_code (eng_code),
        .done       (eng_done),
        .result     (eng_result)
    );

    // ----------------------------------------------------------------
    // analog-side outputs
    // ----------------------------------------------------------------
    // registered copies so the top outputs come from flops
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            analog_select <= 3'h0;
            sample_hold   <= 1'b0;
            dac_code      <= 10'h000;
        end else begin
            analog_select <= {group_select_bit, cur_chan};
            sample_hold   <= eng_sampling & eng_busy;
            dac_code      <= eng_code;
        end
    end

    // ----------------------------------------------------------------
    // result registers
    // ----------------------------------------------------------------
    // left-justified result written to the register of its input
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result_reg_a <= `RESULT_RESET;
            result_reg_b <= `RESULT_RESET;
            result_reg_c <= `RESULT_RESET;
            result_reg_d <= `RESULT_RESET;
        end else if (standby) begin
            result_reg_a <= `RESULT_RESET;
            result_reg_b <= `RESULT_RESET;
            result_reg_c <= `RESULT_RESET;
            result_reg_d <= `RESULT_RESET;
        end else if (eng_done) begin
            case (cur_chan)
                2'h0:    result_reg_a <= {eng_result, `RESULT_PAD};
                2'h1:    result_reg_b <= {eng_result, `RESULT_PAD};
                2'h2:    result_reg_c <= {eng_result, `RESULT_PAD};
                default: result_reg_d <= {eng_result, `RESULT_PAD};
            endcase
        end
    end

    // ----------------------------------------------------------------
    // end flag and interrupt request
    // ----------------------------------------------------------------
    // clear needs a status read that saw the flag at 1; a set wins over it
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_end_flag <= 1'b0;
            flag_armed    <= 1'b0;
            conv_end_irq  <= 1'b0;
        end else if (standby) begin
            conv_end_flag <= 1'b0;
            flag_armed    <= 1'b0;
            conv_end_irq  <= 1'b0;
        end else begin
            if (flag_set) begin
                conv_end_flag <= 1'b1;
            end else if (flag_write_zero && flag_armed) begin
                conv_end_flag <= 1'b0;
            end
            if (flag_set || (flag_write_zero && flag_armed))
                flag_armed <= 1'b0;
            else if (status_read && conv_end_flag)
                flag_armed <= 1'b1;
            conv_end_irq <= conv_irq_enable &
                            (flag_set | (conv_end_flag &
                             ~(flag_write_zero & flag_armed)));
        end
    end

    // ----------------------------------------------------------------
    // byte read port
    // ----------------------------------------------------------------
    // word addressed by an upper read
    assign rd_word = pick(rd_sel, result_reg_a, result_reg_b, result_reg_c, result_reg_d);

    // upper read fills the latch; lower read returns the latch only
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data    <= `BYTE_RESET;
            hold_latch <= `BYTE_RESET;
        end else if (rd_upper) begin
            rd_data    <= rd_word[15:8];
            hold_latch <= rd_word[7:0];
        end else if (rd_lower) begin
            rd_data <= hold_latch;
        end
    end

endmodule // adc_sequencer

// ---- testbench/analog_front_model.sv ----
// comparator model standing behind the sequencer's analog pins
// assumes dac_code and analog_select come straight from the sequencer
`timescale 1ns/1ps

module analog_front_model (
    input  wire [9:0] dac_code,      // trial code from the sequencer
    input  wire [2:0] analog_select, // input routed to the sample-and-hold
    output wire       comp_in        // high while the input is at or above the code
);
    // each input holds a distinct fixed level, keeping the tried bit when at or above
    wire [9:0] level = {analog_select, analog_select, analog_select, 1'b1};
    assign comp_in = (level >= dac_code);
endmodule // analog_front_model

// ---- testbench/adc_seq_assertions.sv ----
// checker on the sequencer's ports: start bit, end flag, interrupt and timing
// assumes a single clock domain and binding to every adc_sequencer
`timescale 1ns/1ps

module adc_seq_checker (
    input wire clk,                // system clock
    input wire reset_n,            // reset, active low
    input wire standby,            // standby level
    input wire half_rate_pclk,     // half-rate peripheral clock
    input wire start_set,          // start write
    input wire start_clear,        // stop write
    input wire scan_mode,          // scan select
    input wire fast_clock_select,  // short conversion
    input wire conv_irq_enable,    // interrupt enable
    input wire ext_trigger_enable, // trigger enable
    input wire flag_write_zero,    // flag clear write
    input wire conv_start_bit,     // start bit
    input wire conv_end_flag,      // end flag
    input wire conv_end_irq        // interrupt request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a single conversion launched at full peripheral rate
    sequence s_single(f);
        $rose(conv_start_bit) && !scan_mode && fast_clock_select == f && !half_rate_pclk;
    endsequence
    a_slow_time: assert property (s_single(1'b0) |-> ##90 conv_start_bit ##[160:180] !conv_start_bit)
        else $error("slow conversion length wrong");
    a_fast_time: assert property (s_single(1'b1) |-> ##46 conv_start_bit ##[74:90] !conv_start_bit)
        else $error("fast conversion length wrong");
    a_start_on_set: assert property (start_set && !start_clear && !standby && !conv_start_bit |=> conv_start_bit)
        else $error("start bit did not rise");
    a_stop_on_clear: assert property (start_clear |=> !conv_start_bit)
        else $error("start bit not cleared");
    a_flag_clear_cause: assert property ($fell(conv_end_flag) |-> $past(flag_write_zero) || $past(standby))
        else $error("end flag fell without a clear");
    a_flag_needs_start: assert property ($rose(conv_end_flag) |-> $past(conv_start_bit))
        else $error("end flag rose without conversion");
    a_single_self_clear: assert property ($rose(conv_end_flag) && !scan_mode |-> !conv_start_bit)
        else $error("start bit kept after single end");
    a_trigger_needs_enable: assert property ($rose(conv_start_bit) && !$past(start_set) |-> $past(ext_trigger_enable))
        else $error("start without enabled trigger");
    a_scan_keeps_running: assert property (conv_start_bit && scan_mode && !start_clear && !standby |=> conv_start_bit)
        else $error("scan stopped by itself");
    a_irq_needs_flag: assert property (conv_end_irq |-> conv_end_flag || $past(conv_end_flag))
        else $error("interrupt without end flag");
    a_irq_follows_flag: assert property (conv_end_flag && $past(conv_end_flag) && conv_irq_enable && $past(conv_irq_enable) |-> conv_end_irq)
        else $error("interrupt missing");
endmodule // adc_seq_checker

bind adc_sequencer adc_seq_checker adc_seq_checker_inst (.clk(clk), .reset_n(reset_n), .standby(standby),
    .half_rate_pclk(half_rate_pclk), .start_set(start_set), .start_clear(start_clear),
    .scan_mode(scan_mode), .fast_clock_select(fast_clock_select), .conv_irq_enable(conv_irq_enable),
    .ext_trigger_enable(ext_trigger_enable), .flag_write_zero(flag_write_zero),
    .conv_start_bit(conv_start_bit), .conv_end_flag(conv_end_flag), .conv_end_irq(conv_end_irq));

// ---- testbench/test_adc_sequencer.sv ----
// self-checking bench for the converter sequencer and byte read port
// assumes the comparator model in analog_front_model.sv
`timescale 1ns/1ps

module test_adc_sequencer;
    reg        clk = 1'b0;   // system clock
    reg        reset_n = 1'b0; // reset, active low
    reg  [4:0] ctl = 5'h00;  // standby, start_set, start_clear, status_read, flag_write_zero
    reg  [6:0] mode = 7'h00; // half, scan, fast, group, ch1, ch0, irq enable
    reg        trg_en = 1'b0; // trigger enable
    reg        trg_n = 1'b1;  // trigger pin
    reg        rd_up = 1'b0;  // upper read
    reg        rd_lo = 1'b0;  // lower read
    reg  [1:0] sel = 2'h0;    // result register
    wire       comp;          // comparator
    wire [7:0] rd_data;       // read data
    wire       sbit, flag, irq, sh; // status outputs
    wire [2:0] asel;          // routed input
    wire [9:0] code;          // trial code
    integer    fails = 0, compares = 0, i, n;
    reg  [7:0] d;             // last read byte
    reg  [9:0] v;             // expected level
    reg [12:0] rows [0:7];    // expected upper byte, half, fast, group, ch1, ch0

    always #12.5 clk = ~clk;

    adc_sequencer adc_sequencer_inst (.clk(clk), .reset_n(reset_n), .standby(ctl[4]),
        .half_rate_pclk(mode[6]), .start_set(ctl[3]), .start_clear(ctl[2]), .scan_mode(mode[5]),
        .fast_clock_select(mode[4]), .group_select_bit(mode[3]), .channel_select_bit1(mode[2]),
        .channel_select_bit0(mode[1]), .conv_irq_enable(mode[0]), .ext_trigger_enable(trg_en),
        .ext_trigger_n(trg_n), .status_read(ctl[1]), .flag_write_zero(ctl[0]), .rd_upper(rd_up),
        .rd_lower(rd_lo), .rd_sel(sel), .comp_in(comp), .rd_data(rd_data), .conv_start_bit(sbit),
        .conv_end_flag(flag), .conv_end_irq(irq), .analog_select(asel), .sample_hold(sh),
        .dac_code(code));
    analog_front_model analog_front_model_inst (.dac_code(code), .analog_select(asel), .comp_in(comp));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    function [9:0] level(input [2:0] c);
        level = {c, c, c, 1'b1};
    endfunction
    task check(input [15:0] seen, input [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task pulse(input [4:0] p);
        begin
            @(negedge clk) ctl = p;
            @(negedge clk) ctl = 5'h00;
        end
    endtask
    task rd(input up, input [1:0] s);
        begin
            @(negedge clk) begin rd_up = up; rd_lo = !up; sel = s; end
            @(negedge clk) begin rd_up = 1'b0; rd_lo = 1'b0; end
            d = rd_data;
        end
    endtask
    task wait_flag;
        begin
            n = 0;
            while (flag !== 1'b1 && n < 1200) begin @(negedge clk); n = n + 1; end
            if (n == 1200) fails = fails + 1;
        end
    endtask
    task stop_test;
        begin
            if (fails == 0 && compares > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rows[0] = 13'h0481;
        rows[1] = 13'h0008;
        rows[2] = 13'h0932;
        rows[3] = 13'h0DBB;
        rows[4] = 13'h1244;
        rows[5] = 13'h16CD;
        rows[6] = 13'h1B76;
        rows[7] = 13'h1FEF;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        rd(1'b0, 2'h0);
        check(d, 8'h00);
        rd(1'b1, 2'h3);
        check(d, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            @(negedge clk) begin mode = {rows[i][4], 1'b0, rows[i][3:0], 1'b1}; ctl = 5'h08; end
            @(negedge clk) ctl = 5'h00;
            wait_flag;
            check(sbit, 1'b0);
            check(irq, 1'b1);
            check(sh, 1'b0);
            pulse(5'h01);
            check(flag, 1'b1);
            pulse(5'h02);
            pulse(5'h01);
            check(flag, 1'b0);
            v = level(rows[i][2:0]);
            check(code, v);
            rd(1'b1, rows[i][1:0]);
            check(d, rows[i][12:5]);
            rd(1'b0, 2'h0);
            check(d, {v[1:0], 6'h00});
        end
        rd(1'b0, 2'h0);
        check(d, {v[1:0], 6'h00});
        // trigger ignored while disabled, then honoured
        @(negedge clk) begin mode = 7'h04; trg_n = 1'b0; end
        repeat (6) @(negedge clk);
        check(sbit, 1'b0);
        @(negedge clk) trg_n = 1'b1;
        repeat (4) @(negedge clk);
        @(negedge clk) begin trg_en = 1'b1; trg_n = 1'b0; end
        repeat (5) @(negedge clk);
        check(sbit, 1'b1);
        wait_flag;
        check(irq, 1'b0);
        v = level(3'h2);
        rd(1'b1, 2'h2);
        check(d, v[9:2]);
        pulse(5'h02);
        pulse(5'h01);
        @(negedge clk) begin trg_en = 1'b0; trg_n = 1'b1; end
        // scan of inputs 4 and 5
        @(negedge clk) begin mode = 7'h2B; ctl = 5'h08; end
        @(negedge clk) ctl = 5'h00;
        wait_flag;
        check(sbit, 1'b1);
        pulse(5'h02);
        pulse(5'h01);
        wait_flag;
        check(n[15:0], 16'h01FC);
        v = level(3'h4);
        rd(1'b1, 2'h0);
        check(d, v[9:2]);
        v = level(3'h5);
        rd(1'b1, 2'h1);
        check(d, v[9:2]);
        repeat (290) @(negedge clk);
        pulse(5'h04);
        check(sbit, 1'b0);
        pulse(5'h08);
        repeat (4) @(negedge clk);
        check(asel, 3'h4);
        // sampling window opens after the synchronisation delay
        repeat (10) @(negedge clk);
        check(sh, 1'b1);
        pulse(5'h10);
        check(sbit, 1'b0);
        rd(1'b1, 2'h0);
        check(d, 8'h00);
        stop_test;
    end

    // watchdog well beyond the expected run length
    initial begin
        #1000000;
        fails = fails + 1;
        stop_test;
    end
endmodule // test_adc_sequencer
